// ### core/sac_conv_readout.sv
// Summary of operation
// - parallel mode drives result bit 11 and bits 12 to 15 on data pins.
// - serial mode leaves data pins 12 to 15 undriven.
// - serial mode with external clock turns pin 11 into incomplete-read flag.
// - external serial read unfinished at next conversion end pulses the flag high.
// - busy rises at start, falls when result is latched for shifting.
// - output drivers on only while chip select and read are both low.
// - external serial clock is ignored while chip select is high.
// - reset high clears logic and aborts any conversion.
// - power-down lets current conversion finish, then blocks starts, reduces power.
// - falling start edge puts sampler in hold and begins conversion.
// - low-power mode with fast mode off starts at once if start already low after acquisition.
// - serial clock pin driven by device on internal clock, input on external.
// - serial data shifts out most significant bit first.
// - external clock updates data on rising edge, or falling when inverted.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_conv_readout #(
  parameter int unsigned ACQ_CYC  = `SAC_ACQ_CYC,
  parameter int unsigned BIT_CYC  = `SAC_BIT_CYC,
  parameter int unsigned ERR_CYC  = `SAC_ERR_CYC,
  parameter int unsigned HALF_CYC = `SAC_SCLK_HALF_CYC
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  serial_clock_in,
  input  wire logic                  conversion_start_n_in,
  input  wire logic                  power_down_in,
  input  wire logic                  low_power_mode_in,
  input  wire logic                  fast_mode_in,
  input  wire logic                  serial_not_parallel_select_in,
  input  wire logic                  clock_source_select_in,
  input  wire logic                  serial_clock_invert_in,
  input  wire logic                  chip_select_n_in,
  input  wire logic                  read_n_in,
  input  wire logic                  comparator_in,
  output logic                       sample_hold_out,
  output logic [`SAC_WIDTH-1:0]      dac_code_out,
  output logic                       busy_out,
  output logic                       power_reduced_out,
  output logic [`SAC_WIDTH-1:0]      data_out,
  output logic [`SAC_WIDTH-1:0]      data_oe_out
);
  import sac_pkg::*;

  function automatic logic [3:0] msb_index(input logic [4:0] n);
    return `SAC_BIT_MSB - n[3:0];
  endfunction : msb_index

  // pin synchronisers (core domain)
  // start and read strobes enter inverted so a cleared stage
  // reads as idle and no false start edge follows reset
  logic       cnv_n_s;
  logic       pd_s;
  logic       rd_cs_n_s;
  logic       link_act_s;
  logic       link_act_q;
  logic [3:0] sync_q;

  sac_sync #(.W(4)) u_sync (
    .clk_in (ref_clk_in),
    .rst_in (rst_in),
    .d_in   ({~conversion_start_n_in, power_down_in, ~(chip_select_n_in | read_n_in), link_act_q}),
    .q_out  (sync_q)
  );
  assign cnv_n_s    = ~sync_q[3];
  assign pd_s       = sync_q[2];
  assign rd_cs_n_s  = ~sync_q[1];
  assign link_act_s = sync_q[0];

  logic ser_mode;
  logic ext_mode;
  logic impulse;
  logic rd_en;
  assign ser_mode = serial_not_parallel_select_in;
  assign ext_mode = ser_mode & clock_source_select_in;
  assign impulse  = low_power_mode_in & ~fast_mode_in;
  assign rd_en    = ~chip_select_n_in & ~read_n_in;

  // conversion sequencer
  sac_state_t            st_q;
  sac_state_t            st_d;
  logic [7:0]            tmr_q;
  logic [7:0]            tmr_d;
  logic [`SAC_WIDTH-1:0] code_q;
  logic [`SAC_WIDTH-1:0] code_d;
  logic [3:0]            bit_q;
  logic [3:0]            bit_d;
  logic [`SAC_WIDTH-1:0] result_q;
  logic [`SAC_WIDTH-1:0] result_d;
  logic                  cnv_prev_q;
  logic                  cnv_fall;
  logic                  conv_done;

  assign cnv_fall = cnv_prev_q & ~cnv_n_s;

  always_comb begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    code_d    = code_q;
    bit_d     = bit_q;
    result_d  = result_q;
    conv_done = 1'b0;
    unique case (st_q)
      SAC_ST_ACQ: begin
        if (tmr_q >= 8'(ACQ_CYC - 1)) begin
          st_d  = SAC_ST_READY;
          tmr_d = 8'h00;
        end else begin
          tmr_d = tmr_q + 8'h01;
        end
      end
      SAC_ST_READY: begin
        if (!pd_s && (cnv_fall || (impulse && !cnv_n_s))) begin
          st_d   = SAC_ST_CONV;
          tmr_d  = 8'h00;
          code_d = `SAC_CODE_START;
          bit_d  = `SAC_BIT_MSB;
        end
      end
      SAC_ST_CONV: begin
        if (tmr_q >= 8'(BIT_CYC - 1)) begin
          tmr_d         = 8'h00;
          code_d[bit_q] = comparator_in;
          if (bit_q != 4'h0) begin
            code_d[bit_q - 4'h1] = 1'b1;
            bit_d                = bit_q - 4'h1;
          end else begin
            result_d  = code_d;
            conv_done = 1'b1;
            st_d      = SAC_ST_ACQ;
          end
        end else begin
          tmr_d = tmr_q + 8'h01;
        end
      end
      default: st_d = SAC_ST_ACQ;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q       <= SAC_ST_ACQ;
      tmr_q      <= 8'h00;
      code_q     <= '0;
      bit_q      <= 4'h0;
      result_q   <= '0;
      cnv_prev_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      tmr_q      <= tmr_d;
      code_q     <= code_d;
      bit_q      <= bit_d;
      result_q   <= result_d;
      cnv_prev_q <= cnv_n_s;
    end
  end

  assign busy_out          = (st_q == SAC_ST_CONV);
  assign sample_hold_out   = (st_q == SAC_ST_CONV);
  assign dac_code_out      = code_q;
  assign power_reduced_out = pd_s & (st_q != SAC_ST_CONV);

  // incomplete-read flag
  // a fresh set wins over the countdown
  logic [7:0] err_q;
  logic [7:0] err_d;

  always_comb begin
    err_d = (err_q != 8'h00) ? err_q - 8'h01 : 8'h00;
    if (conv_done && ext_mode && link_act_s) begin
      err_d = 8'(ERR_CYC);
    end
  end

  // internal-clock serial read
  logic       run_q;
  logic       run_d;
  logic       sent_q;
  logic       sent_d;
  logic       sclk_q;
  logic       sclk_d;
  logic       isdo_q;
  logic       isdo_d;
  logic [4:0] icnt_q;
  logic [4:0] icnt_d;
  logic [7:0] div_q;
  logic [7:0] div_d;

  always_comb begin
    run_d  = run_q;
    sent_d = sent_q;
    sclk_d = sclk_q;
    isdo_d = isdo_q;
    icnt_d = icnt_q;
    div_d  = div_q;
    if (!run_q) begin
      if (ser_mode && !ext_mode && !rd_cs_n_s && !busy_out && !sent_q) begin
        run_d  = 1'b1;
        icnt_d = 5'h00;
        div_d  = 8'h00;
        isdo_d = result_q[`SAC_BIT_MSB];
      end
    end else if (rd_cs_n_s || ext_mode || !ser_mode) begin
      run_d  = 1'b0;
      sclk_d = 1'b0;
    end else if (div_q >= 8'(HALF_CYC - 1)) begin
      div_d  = 8'h00;
      sclk_d = ~sclk_q;
      if (sclk_q) begin
        // data moves on the falling edge so the rising edge sees it settled
        icnt_d = icnt_q + 5'h01;
        if (icnt_d == `SAC_BITS_DONE) begin
          run_d  = 1'b0;
          sent_d = 1'b1;
          isdo_d = 1'b0;
        end else begin
          isdo_d = result_q[msb_index(icnt_d)];
        end
      end
    end else begin
      div_d = div_q + 8'h01;
    end
    if (conv_done) begin
      sent_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_q  <= 8'h00;
      run_q  <= 1'b0;
      sent_q <= 1'b0;
      sclk_q <= 1'b0;
      isdo_q <= 1'b0;
      icnt_q <= 5'h00;
      div_q  <= 8'h00;
    end else begin
      err_q  <= err_d;
      run_q  <= run_d;
      sent_q <= sent_d;
      sclk_q <= sclk_d;
      isdo_q <= isdo_d;
      icnt_q <= icnt_d;
      div_q  <= div_d;
    end
  end

  // external-clock serial read (link domain)
  // chip select comes from the same master as the serial clock, so it
  // acts directly as the frame gate and clears the bit count between frames
  logic       link_clk;
  logic       link_rst;
  logic [4:0] lcnt_q;
  logic [4:0] lcnt_d;
  logic       link_act_d;
  logic       esdo;

  assign link_clk = serial_clock_in ^ serial_clock_invert_in;
  assign link_rst = rst_in | chip_select_n_in | ~ext_mode;

  always_comb begin
    lcnt_d     = (lcnt_q == `SAC_BITS_DONE) ? lcnt_q : lcnt_q + 5'h01;
    link_act_d = (lcnt_d != 5'h00) && (lcnt_d != `SAC_BITS_DONE);
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      lcnt_q     <= 5'h00;
      link_act_q <= 1'b0;
    end else begin
      lcnt_q     <= lcnt_d;
      link_act_q <= link_act_d;
    end
  end

  // result word stays put for the whole frame unless a new conversion ends
  assign esdo = (lcnt_q == `SAC_BITS_DONE) ? 1'b0 : result_q[msb_index(lcnt_q)];

  // pin mux and drivers
  always_comb begin
    data_out    = '0;
    data_oe_out = '0;
    if (!ser_mode) begin
      data_out = result_q;
      if (rd_en) begin
        data_oe_out = '1;
      end
    end else begin
      data_out[`SAC_PIN_SDO]  = ext_mode ? esdo : isdo_q;
      data_out[`SAC_PIN_SCLK] = sclk_q;
      data_out[`SAC_PIN_FLAG] = (err_q != 8'h00);
      // pins 12 to 15 stay undriven in serial mode
      data_oe_out[`SAC_PIN_SDO]  = rd_en;
      data_oe_out[`SAC_PIN_SCLK] = rd_en & ~ext_mode;
      data_oe_out[`SAC_PIN_FLAG] = rd_en & ext_mode;
    end
  end
endmodule : sac_conv_readout

// ### core/sac_params.svh
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_WIDTH          16
`define SAC_CLK_PERIOD_NS  20
`define SAC_ACQ_TIME_NS    250
`define SAC_ACQ_CYC        ((`SAC_ACQ_TIME_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_BIT_TIME_NS    60
`define SAC_BIT_CYC        ((`SAC_BIT_TIME_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_ERR_TIME_NS    100
`define SAC_ERR_CYC        (`SAC_ERR_TIME_NS / `SAC_CLK_PERIOD_NS)
`define SAC_SCLK_HALF_NS   40
`define SAC_SCLK_HALF_CYC  ((`SAC_SCLK_HALF_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_CODE_START     16'h8000
`define SAC_BIT_MSB        4'hf
`define SAC_BITS_DONE      5'h10
`define SAC_PIN_SDO        8
`define SAC_PIN_SCLK       9
`define SAC_PIN_FLAG       11

`endif

// ### core/sac_pkg.sv
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_ST_ACQ   = 2'b00,
    SAC_ST_READY = 2'b01,
    SAC_ST_CONV  = 2'b10
  } sac_state_t;
endpackage : sac_pkg

// ### core/sac_sync.sv
`timescale 1ns/1ps
module sac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : sac_sync

// ### verification/sac_conv_readout_assertions.sv
`timescale 1ns/1ps
module sac_conv_readout_assertions #(
  parameter int unsigned BIT_CYC = 3
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        power_down_in,
  input wire logic        serial_not_parallel_select_in,
  input wire logic        clock_source_select_in,
  input wire logic        chip_select_n_in,
  input wire logic        read_n_in,
  input wire logic        sample_hold_out,
  input wire logic [15:0] dac_code_out,
  input wire logic        busy_out,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe_out
);
  localparam int CONV = 16 * BIT_CYC - 1;
  wire ser = serial_not_parallel_select_in;
  wire ext = clock_source_select_in;
  wire rd_on = !chip_select_n_in && !read_n_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence conv_end;
    ##CONV busy_out ##1 !busy_out && !sample_hold_out;
  endsequence
  sequence err_cause;
    $fell(busy_out);
  endsequence
  AST_START: assert property ($rose(busy_out) |-> sample_hold_out && dac_code_out == 16'h8000)
    else $error("start without hold");
  AST_SPAN: assert property ($rose(busy_out) |-> conv_end)
    else $error("busy span wrong");
  AST_OE_OFF: assert property (!rd_on |-> data_oe_out == 16'h0)
    else $error("driving while not read");
  AST_PAR_OE: assert property (rd_on && !ser |-> data_oe_out == 16'hffff)
    else $error("parallel bus not driven");
  AST_SER_PINS: assert property (rd_on && ser |-> !data_oe_out[15:12] && data_oe_out[11:9] == {ext, 1'b0, !ext})
    else $error("serial pin use wrong");
  AST_ERR: assert property ($rose(data_out[11]) && ser && ext |-> err_cause ##0 data_out[11] [*5] ##1 !data_out[11])
    else $error("flag pulse wrong");
  AST_PD: assert property (power_down_in [*6] ##0 !busy_out |=> !busy_out)
    else $error("start while powered down");
  AST_IDLE: assert property ($fell(rst_in) |-> !busy_out && !sample_hold_out)
    else $error("not idle after reset");
endmodule : sac_conv_readout_assertions

// ### verification/sac_host_model.sv
`timescale 1ns/1ps
module sac_host_model (
  input  wire logic [15:0] dac_code_in,
  input  wire logic [15:0] target_in,
  output logic             comparator_out,
  output logic             serial_clock_out
);
  // front end holding target_in: trial bit kept unless it overshoots
  assign comparator_out = dac_code_in <= target_in;
  // link clock stands low between pulses, 6 ns period
  initial serial_clock_out = 1'b0;
  task automatic rise;
    serial_clock_out = 1'b1;
    #3;
  endtask : rise
  task automatic fall;
    serial_clock_out = 1'b0;
    #3;
  endtask : fall
endmodule : sac_host_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  bit          ref_clk_in;
  logic        rst_in, start_n, pd, lp, fast, ser, ext, inv, cs_n, rd_n, sclk, cmp, hold, busy, pr, last;
  logic [15:0] dac, dout, oe, target, word, sh;
  int          mismatches, checked, bits;
  sac_conv_readout sac_conv_readout_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_clock_in(sclk),
    .conversion_start_n_in(start_n), .power_down_in(pd), .low_power_mode_in(lp), .fast_mode_in(fast),
    .serial_not_parallel_select_in(ser), .clock_source_select_in(ext), .serial_clock_invert_in(inv),
    .chip_select_n_in(cs_n), .read_n_in(rd_n), .comparator_in(cmp), .sample_hold_out(hold),
    .dac_code_out(dac), .busy_out(busy), .power_reduced_out(pr), .data_out(dout), .data_oe_out(oe));
  sac_host_model sac_host_model_i (.dac_code_in(dac), .target_in(target), .comparator_out(cmp),
    .serial_clock_out(sclk));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : tick
  task automatic do_reset(input logic s, input logic e);
    rst_in = 1'b1;
    ser = s;
    ext = e;
    tick(4);
    rst_in = 1'b0;
    tick(20);
  endtask : do_reset
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 80 && busy !== v; i++) tick(1);
    check(16'(busy), 16'(v));
  endtask : wait_busy
  task automatic convert(input logic [15:0] t, input logic p);
    tick(15);
    target = t;
    start_n = 1'b0;
    tick(2);
    start_n = 1'b1;
    wait_busy(1'b1);
    pd = p;
    wait_busy(1'b0);
  endtask : convert
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    summarize();
  end
  initial begin
    {start_n, cs_n, rd_n, pd, lp, inv, fast} = 7'h70;
    target = 16'h0;
    do_reset(1'b0, 1'b0);
    check(oe, 16'h0);
    convert(16'ha5c3, 1'b1);
    {cs_n, rd_n} = 2'h0;
    #1 check(oe, 16'hffff);
    check(dout, 16'ha5c3);
    check(16'(pr), 16'h1);
    tick(20);
    start_n = 1'b0;
    tick(40);
    check(16'(busy), 16'h0);
    start_n = 1'b1;
    tick(1);
    {pd, rd_n} = 2'h1;
    #1 check(oe, 16'h0);
    tick(20);
    start_n = 1'b0;
    tick(10);
    check(16'(busy), 16'h1);
    rst_in = 1'b1;
    #1 check(16'({hold, busy}), 16'h0);
    lp = 1'b1;
    do_reset(1'b0, 1'b0);
    wait_busy(1'b1);
    start_n = 1'b1;
    wait_busy(1'b0);
    fast = 1'b1;
    start_n = 1'b0;
    tick(30);
    check(16'(busy), 16'h0);
    {start_n, lp, fast} = 3'h4;
    do_reset(1'b1, 1'b0);
    convert(16'h6b19, 1'b0);
    {rd_n, word, bits, last} = '0;
    for (int i = 0; i < 300 && bits < 16; i++) begin
      @(posedge ref_clk_in);
      #1;
      if (dout[9] === 1'b1 && last === 1'b0) begin
        word = {word[14:0], dout[8]};
        bits++;
      end
      last = dout[9];
    end
    check(word, 16'h6b19);
    for (int v = 0; v < 2; v++) begin
      {inv, cs_n, rd_n} = {v[0], 2'h3};
      do_reset(1'b1, 1'b1);
      convert(16'h9c36, 1'b0);
      sac_host_model_i.rise();
      sac_host_model_i.fall();
      {cs_n, rd_n} = 2'h0;
      sh = 16'h9c36;
      #1 check(16'(dout[8]), 16'h1);
      for (int n = 0; n < 16; n++) begin
        sac_host_model_i.rise();
        sh = inv ? sh : sh << 1;
        check(16'(dout[8]), 16'(sh[15]));
        sac_host_model_i.fall();
        sh = inv ? sh << 1 : sh;
        check(16'(dout[8]), 16'(sh[15]));
      end
      cs_n = 1'b1;
    end
    tick(1);
    cs_n = 1'b0;
    sac_host_model_i.rise();
    sac_host_model_i.fall();
    convert(16'h0f0f, 1'b0);
    bits = 0;
    for (int i = 0; i < 8; i++) begin
      bits += int'(dout[11] === 1'b1);
      tick(1);
    end
    check(16'(bits), 16'h5);
    summarize();
  end
endmodule : testbench
bind sac_conv_readout sac_conv_readout_assertions #(.BIT_CYC(BIT_CYC)) checker_i (.ref_clk_in, .rst_in,
  .power_down_in, .serial_not_parallel_select_in, .clock_source_select_in, .chip_select_n_in, .read_n_in,
  .sample_hold_out, .dac_code_out, .busy_out, .data_out, .data_oe_out);
